// ===== dbcr_pkg.sv
// constants, types and decode helper for the dual buck config registers
package dbcr_pkg;

  localparam int NUM_REGS = 4;

  localparam logic [7:0] ADDR_PHASE_GATE = 8'hd1;
  localparam logic [7:0] ADDR_CC_LIMIT   = 8'hd2;
  localparam logic [7:0] ADDR_ADDR_TEMP  = 8'hd3;
  localparam logic [7:0] ADDR_SWITCHING_RATE_SELECT_WARN  = 8'hd4;

  // reset values, used until the otp image is loaded
  localparam logic [7:0] RST_PHASE_GATE = 8'ha2;
  localparam logic [7:0] RST_CC_LIMIT   = 8'h48;
  localparam logic [7:0] RST_ADDR_TEMP  = 8'h0a;
  localparam logic [7:0] RST_SWITCHING_RATE_SELECT_WARN  = 8'h64;

  // implemented bits per register
  localparam logic [7:0] MASK_PHASE_GATE = 8'hb7;
  localparam logic [7:0] MASK_CC_LIMIT   = 8'hff;
  localparam logic [7:0] MASK_ADDR_TEMP  = 8'hff;
  localparam logic [7:0] MASK_SWITCHING_RATE_SELECT_WARN  = 8'hf7;

  localparam logic [7:0] REG_RST  [NUM_REGS] = '{RST_PHASE_GATE,
    RST_CC_LIMIT, RST_ADDR_TEMP, RST_SWITCHING_RATE_SELECT_WARN};
  localparam logic [7:0] REG_MASK [NUM_REGS] = '{MASK_PHASE_GATE,
    MASK_CC_LIMIT, MASK_ADDR_TEMP, MASK_SWITCHING_RATE_SELECT_WARN};

  localparam int GATE_BIT   = 7;
  localparam int PHASE_LSB  = 4;
  localparam int DRV_LSB    = 1;
  localparam int DITHER_BIT = 0;
  localparam int SADDR_LSB  = 3;
  localparam int TSD_LSB    = 0;
  localparam int SWITCHING_RATE_SELECT_LSB   = 6;
  localparam int SLEW_LSB   = 4;
  localparam int WARN_LSB   = 0;

  // slave address bits a7:a6 are fixed
  localparam logic [1:0] SADDR_FIXED_HI = 2'b11;
  localparam logic [2:0] BIT_LAST       = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACKA = 3'b010,
    ST_WR   = 3'b011,
    ST_ACKW = 3'b100,
    ST_RD   = 3'b101,
    ST_ACKR = 3'b110,
    ST_RDLD = 3'b111
  } dbcr_state_t;

  // {hit, index} for a register pointer
  function automatic logic [2:0] dbcr_decode(input logic [7:0] a);
    logic [7:0] d;
    d = a - ADDR_PHASE_GATE;
    dbcr_decode = {(a >= ADDR_PHASE_GATE) && (a <= ADDR_SWITCHING_RATE_SELECT_WARN), d[1:0]};
  endfunction

endpackage

// ===== dbcr_reg_if.sv
// register access carrier between the serial engine and the bank
`timescale 1ns/1ns
interface dbcr_reg_if;
  logic       we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport host (output we, addr, wdata, input rdata);
  modport bank (input we, addr, wdata, output rdata);
endinterface

// ===== dbcr_regbank.sv
// four configuration registers with otp load and registered read data
`timescale 1ns/1ns
module dbcr_regbank
  import dbcr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        otp_load,
  input  wire logic [31:0] otp_data,
  dbcr_reg_if.bank         rb,
  output logic [7:0]       phase_gate_dither_ctrl,
  output logic [7:0]       cc_limit_setting,
  output logic [7:0]       address_and_shutdown_temp,
  output logic [7:0]       frequency_slew_warning_ctrl
);

  logic [7:0] cfg_reg [NUM_REGS];
  logic [7:0] rdata_reg;
  wire  [2:0] dec = dbcr_decode(rb.addr);
  wire        hit = dec[2];
  wire  [1:0] idx = dec[1:0];

  // otp image wins over a host write in the same cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        cfg_reg[i] <= REG_RST[i];
      end
    end else if (otp_load) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        cfg_reg[i] <= otp_data[8*i +: 8] & REG_MASK[i]; // RULE12 RULE14
      end
    end else if (rb.we && hit) begin
      cfg_reg[idx] <= rb.wdata & REG_MASK[idx]; // RULE12 RULE14
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= hit ? cfg_reg[idx] : 8'h00; // RULE12
    end
  end

  assign rb.rdata                    = rdata_reg;
  assign phase_gate_dither_ctrl      = cfg_reg[0];
  assign cc_limit_setting            = cfg_reg[1];
  assign address_and_shutdown_temp   = cfg_reg[2];
  assign frequency_slew_warning_ctrl = cfg_reg[3];

  wire wr_pg = rb.we && rb.addr == ADDR_PHASE_GATE && !otp_load;
  wire wr_cc = rb.we && rb.addr == ADDR_CC_LIMIT && !otp_load;
  wire wr_at = rb.we && rb.addr == ADDR_ADDR_TEMP && !otp_load;
  wire wr_fw = rb.we && rb.addr == ADDR_SWITCHING_RATE_SELECT_WARN && !otp_load;

  property p_gate_wr;
    @(posedge clock) disable iff (!nrst)
    wr_pg |=> phase_gate_dither_ctrl[GATE_BIT] == $past(rb.wdata[7]);
  endproperty
  a_gate_wr: assert property (p_gate_wr) else $error("gate bit lost"); // RULE1

  property p_phase_wr;
    @(posedge clock) disable iff (!nrst)
    wr_pg |=> phase_gate_dither_ctrl[5:4] == $past(rb.wdata[5:4]);
  endproperty
  a_phase_wr: assert property (p_phase_wr) else $error("phase lost"); // RULE2

  property p_drv_wr;
    @(posedge clock) disable iff (!nrst)
    wr_pg |=> phase_gate_dither_ctrl[2:1] == $past(rb.wdata[2:1]);
  endproperty
  a_drv_wr: assert property (p_drv_wr) else $error("drv level lost"); // RULE3

  property p_dither_wr;
    @(posedge clock) disable iff (!nrst)
    wr_pg ##1 !otp_load && !(rb.we && rb.addr == ADDR_PHASE_GATE)
      |=> phase_gate_dither_ctrl[0] == $past(rb.wdata[0], 2);
  endproperty
  a_dither_wr: assert property (p_dither_wr) else $error("dither lost"); // RULE4

  property p_cc_wr;
    @(posedge clock) disable iff (!nrst)
    wr_cc |=> cc_limit_setting == $past(rb.wdata);
  endproperty
  a_cc_wr: assert property (p_cc_wr) else $error("cc code lost"); // RULE5

  property p_at_wr;
    @(posedge clock) disable iff (!nrst)
    wr_at |=> address_and_shutdown_temp == $past(rb.wdata);
  endproperty
  a_at_wr: assert property (p_at_wr) else $error("addr/tsd lost"); // RULE7 RULE8

  property p_fw_wr;
    @(posedge clock) disable iff (!nrst)
    wr_fw |=> frequency_slew_warning_ctrl[7:4] == $past(rb.wdata[7:4]) &&
      frequency_slew_warning_ctrl[2:0] == $past(rb.wdata[2:0]);
  endproperty
  a_fw_wr: assert property (p_fw_wr) else $error("switching_rate_select/warn lost"); // RULE9 RULE10 RULE11

  property p_otp;
    @(posedge clock) disable iff (!nrst)
    otp_load |=> cc_limit_setting == $past(otp_data[15:8]) &&
      address_and_shutdown_temp == $past(otp_data[23:16]);
  endproperty
  a_otp: assert property (p_otp) else $error("otp not loaded"); // RULE12

  property p_reserved;
    @(posedge clock) disable iff (!nrst)
    (rb.we || otp_load) |=> phase_gate_dither_ctrl[6] == 1'b0 &&
      phase_gate_dither_ctrl[3] == 1'b0 && frequency_slew_warning_ctrl[3] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved set"); // RULE14

  property p_rdata;
    @(posedge clock) disable iff (!nrst)
    !hit |=> rdata_reg == 8'h00;
  endproperty
  a_rdata: assert property (p_rdata) else $error("unmapped read nonzero"); // RULE14

endmodule

// ===== dbcr_top.sv
// serial-bus slave and configuration outputs of the dual buck controller
//
// Function
// [RULE1] phase/gate bit 7 enables both isolation gate drivers, default on.
// [RULE2] bits 5:4 set channel two clock phase offset, default half turn.
// [RULE3] bits 2:1 choose driver supply level, default code 01.
// [RULE4] bit 0 enables spread-spectrum dithering, default off.
// [RULE5] current-limit register holds 8-bit code, 50mA steps, default 72.
// [RULE6] host keeps current-limit code within 1A to 6.4A.
// [RULE7] address register bits 7:3 supply slave address bits A5:A1.
// [RULE8] address register bits 2:0 select thermal-shutdown level, default 010.
// [RULE9] frequency register bits 7:6 pick switching frequency, default 01.
// [RULE10] bits 5:4 pick reference ramp rate, default 10.
// [RULE11] bits 2:0 set thermal warning level, default 100.
// [RULE12] registers are read/write; reset contents come from otp memory.
// [RULE13] default slave address is 61h until address bits change.
// [RULE14] unassigned bits read zero and ignore writes.
`timescale 1ns/1ns
module dbcr_top
  import dbcr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic        otp_load,
  input  wire logic [31:0] otp_data,
  output logic             gate_driver_outputs_on,
  output logic [1:0]       phase_offset_sel,
  output logic [1:0]       driver_supply_level,
  output logic             dither_enable,
  output logic [7:0]       current_limit_code,
  output logic [6:0]       slave_addr,
  output logic [2:0]       shutdown_temp_sel,
  output logic [1:0]       switching_rate_select,
  output logic [1:0]       slew_rate_sel,
  output logic [2:0]       thermal_warning_level
);

  dbcr_reg_if rb ();

  logic [7:0]  pg_cfg;
  logic [7:0]  cc_cfg;
  logic [7:0]  at_cfg;
  logic [7:0]  fw_cfg;

  dbcr_regbank u_bank (
    .clock                       (clock),
    .nrst                        (nrst),
    .otp_load                    (otp_load),
    .otp_data                    (otp_data),
    .rb                          (rb.bank),
    .phase_gate_dither_ctrl      (pg_cfg),
    .cc_limit_setting            (cc_cfg),
    .address_and_shutdown_temp   (at_cfg),
    .frequency_slew_warning_ctrl (fw_cfg)
  );

  assign gate_driver_outputs_on = pg_cfg[GATE_BIT]; // RULE1
  assign phase_offset_sel       = pg_cfg[PHASE_LSB +: 2]; // RULE2
  assign driver_supply_level    = pg_cfg[DRV_LSB +: 2]; // RULE3
  assign dither_enable          = pg_cfg[DITHER_BIT]; // RULE4
  assign current_limit_code     = cc_cfg; // RULE5
  assign slave_addr = {SADDR_FIXED_HI, at_cfg[SADDR_LSB +: 5]}; // RULE7 RULE13
  assign shutdown_temp_sel      = at_cfg[TSD_LSB +: 3]; // RULE8
  assign switching_rate_select  = fw_cfg[SWITCHING_RATE_SELECT_LSB +: 2]; // RULE9
  assign slew_rate_sel          = fw_cfg[SLEW_LSB +: 2]; // RULE10
  assign thermal_warning_level  = fw_cfg[WARN_LSB +: 3]; // RULE11

  dbcr_state_t state_reg;
  dbcr_state_t state_next;
  logic        scl_reg;
  logic        sda_reg;
  logic [2:0]  cnt_reg;
  logic [2:0]  cnt_next;
  logic [7:0]  shift_reg;
  logic [7:0]  shift_next;
  logic [7:0]  tx_reg;
  logic [7:0]  tx_next;
  logic [7:0]  ptr_reg;
  logic [7:0]  ptr_next;
  logic        ptr_set_reg;
  logic        ptr_set_next;
  logic        rw_reg;
  logic        rw_next;
  logic        oe_n_reg;
  logic        oe_n_next;
  logic        we_c;

  // bus conditions, sampled against the previous level
  wire scl_rise  = scl_in & ~scl_reg;
  wire scl_fall  = ~scl_in & scl_reg;
  wire start_det = scl_in & scl_reg & sda_reg & ~sda_in;
  wire stop_det  = scl_in & scl_reg & ~sda_reg & sda_in;
  wire [7:0] shift_in  = {shift_reg[6:0], sda_in};
  wire       last_bit  = cnt_reg == BIT_LAST;
  wire [2:0] cnt_inc   = cnt_reg + 3'h1;
  wire [7:0] ptr_inc   = ptr_reg + 8'h01;
  wire       addr_hit  = shift_reg[6:0] == slave_addr; // RULE7 RULE13

  assign rb.we    = we_c;
  assign rb.addr  = ptr_reg;
  assign rb.wdata = shift_in;

  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    shift_next   = shift_reg;
    tx_next      = tx_reg;
    ptr_next     = ptr_reg;
    ptr_set_next = ptr_set_reg;
    rw_next      = rw_reg;
    oe_n_next    = oe_n_reg;
    we_c         = 1'b0;
    if (start_det) begin
      state_next   = ST_ADDR;
      cnt_next     = 3'h0;
      oe_n_next    = 1'b1;
      ptr_set_next = 1'b0;
    end else if (stop_det) begin
      state_next = ST_IDLE;
      oe_n_next  = 1'b1;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (scl_rise) begin
            shift_next = shift_in;
            cnt_next   = cnt_inc;
            if (last_bit) begin
              rw_next    = sda_in;
              state_next = addr_hit ? ST_ACKA : ST_IDLE; // RULE13
            end
          end
        end
        ST_ACKA: begin
          if (scl_fall) begin
            cnt_next = 3'h0;
            if (oe_n_reg) begin
              oe_n_next = 1'b0;
            end else if (rw_reg) begin
              state_next = ST_RD;
              tx_next    = rb.rdata;
              oe_n_next  = rb.rdata[7];
            end else begin
              state_next = ST_WR;
              oe_n_next  = 1'b1;
            end
          end
        end
        ST_WR: begin
          if (scl_rise) begin
            shift_next = shift_in;
            cnt_next   = cnt_inc;
            if (last_bit) begin
              state_next = ST_ACKW;
              if (ptr_set_reg) begin
                we_c     = 1'b1; // RULE12
                ptr_next = ptr_inc;
              end else begin
                ptr_next     = shift_in;
                ptr_set_next = 1'b1;
              end
            end
          end
        end
        ST_ACKW: begin
          if (scl_fall) begin
            cnt_next = 3'h0;
            if (oe_n_reg) begin
              oe_n_next = 1'b0;
            end else begin
              state_next = ST_WR;
              oe_n_next  = 1'b1;
            end
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            cnt_next = cnt_inc;
            if (last_bit) begin
              state_next = ST_ACKR;
            end
          end else if (scl_fall) begin
            tx_next   = {tx_reg[6:0], 1'b0};
            oe_n_next = tx_reg[6];
          end
        end
        ST_ACKR: begin
          if (scl_fall) begin
            oe_n_next = 1'b1;
          end else if (scl_rise) begin
            if (!sda_in) begin
              ptr_next   = ptr_inc;
              state_next = ST_RDLD;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
        ST_RDLD: begin
          if (scl_fall) begin
            state_next = ST_RD;
            cnt_next   = 3'h0;
            tx_next    = rb.rdata; // RULE12
            oe_n_next  = rb.rdata[7];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg   <= ST_IDLE;
      scl_reg     <= 1'b1;
      sda_reg     <= 1'b1;
      cnt_reg     <= 3'h0;
      shift_reg   <= 8'h00;
      tx_reg      <= 8'h00;
      ptr_reg     <= 8'h00;
      ptr_set_reg <= 1'b0;
      rw_reg      <= 1'b0;
      oe_n_reg    <= 1'b1;
      sda_out     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      scl_reg     <= scl_in;
      sda_reg     <= sda_in;
      cnt_reg     <= cnt_next;
      shift_reg   <= shift_next;
      tx_reg      <= tx_next;
      ptr_reg     <= ptr_next;
      ptr_set_reg <= ptr_set_next;
      rw_reg      <= rw_next;
      oe_n_reg    <= oe_n_next;
      sda_out     <= 1'b0;
    end
  end

  assign sda_oe_n = oe_n_reg;

  property p_addr_miss;
    @(posedge clock) disable iff (!nrst)
    state_reg == ST_ADDR && scl_rise && last_bit && !start_det && !stop_det
      && shift_reg[6:0] != {SADDR_FIXED_HI, at_cfg[7:3]}
      |=> state_reg == ST_IDLE ##1 sda_oe_n;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign addr taken"); // RULE13

  property p_addr_ack;
    @(posedge clock) disable iff (!nrst)
    state_reg == ST_ACKA && scl_fall && oe_n_reg && !start_det && !stop_det
      |=> !sda_oe_n;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("no address ack"); // RULE7

endmodule

// ===== dbcr_host_model.sv
// serial bus host model for the configuration register bank
`timescale 1ns/1ns
module dbcr_host_model (
  input  wire logic clock,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // each bus phase lasts four system clocks
  task automatic half();
    repeat (4) @(negedge clock);
  endtask

  // data only changes while the serial clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    half();
    scl = 1'b1;
    half();
    r = sda_wire;
    scl = 1'b0;
    half();
  endtask

  task automatic start();
    sda_drv = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b0;
    half();
    scl = 1'b0;
    half();
  endtask

  task automatic stop();
    sda_drv = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b1;
    half();
  endtask

  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] p, d,
                    output logic ack);
    logic k1, k2, k3;
    start();
    send({a, 1'b0}, k1);
    send(p, k2);
    send(d, k3);
    stop();
    ack = k1 & k2 & k3;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] p,
                    output logic [7:0] d, output logic ack);
    logic k1, k2, k3;
    start();
    send({a, 1'b0}, k1);
    send(p, k2);
    start();
    send({a, 1'b1}, k3);
    recv(1'b1, d);
    stop();
    ack = k1 & k2 & k3;
  endtask

  // two data bytes in one frame, pointer advances between them
  task automatic wr2(input logic [6:0] a, input logic [7:0] p, d0, d1,
                     output logic ack);
    logic k1, k2, k3, k4;
    start();
    send({a, 1'b0}, k1);
    send(p, k2);
    send(d0, k3);
    send(d1, k4);
    stop();
    ack = k1 & k2 & k3 & k4;
  endtask

  // host acks the first byte so the pointer moves on
  task automatic rd2(input logic [6:0] a, input logic [7:0] p,
                     output logic [7:0] d0, d1, output logic ack);
    logic k1, k2, k3;
    start();
    send({a, 1'b0}, k1);
    send(p, k2);
    start();
    send({a, 1'b1}, k3);
    recv(1'b0, d0);
    recv(1'b1, d1);
    stop();
    ack = k1 & k2 & k3;
  endtask
endmodule

// ===== testbench.sv
// self-checking bench for the dual buck configuration registers
`timescale 1ns/1ns
module testbench;
  import dbcr_pkg::*;
  logic        clock;
  logic        nrst;
  logic        scl;
  logic        sda_drv;
  wire         sda_wire;
  logic        sda_out;
  logic        sda_oe_n;
  logic        otp_load;
  logic [31:0] otp_data;
  logic        gate_on;
  logic [1:0]  phase;
  logic [1:0]  drv;
  logic        dither;
  logic [7:0]  limit;
  logic [6:0]  slave_addr;
  logic [2:0]  tsd;
  logic [1:0]  rate;
  logic [1:0]  slew;
  logic [2:0]  warn;
  int          error_cnt;
  int          check_count;
  logic        ack;
  logic [7:0]  rd;
  logic [2:0]  c;
  logic [7:0]  d;
  logic [7:0]  tab [4];

  // open drain wire with pull-up
  assign sda_wire = sda_drv & (sda_oe_n | sda_out);
  wire [7:0] out_pg = {gate_on, 1'b0, phase, 1'b0, drv, dither};
  wire [7:0] out_at = {slave_addr[4:0], tsd};
  wire [7:0] out_fw = {rate, slew, 1'b0, warn};

  dbcr_top u_dut (
    .clock                  (clock),
    .nrst                   (nrst),
    .scl_in                 (scl),
    .sda_in                 (sda_wire),
    .sda_out                (sda_out),
    .sda_oe_n               (sda_oe_n),
    .otp_load               (otp_load),
    .otp_data               (otp_data),
    .gate_driver_outputs_on (gate_on),
    .phase_offset_sel       (phase),
    .driver_supply_level    (drv),
    .dither_enable          (dither),
    .current_limit_code     (limit),
    .slave_addr             (slave_addr),
    .shutdown_temp_sel      (tsd),
    .switching_rate_select  (rate),
    .slew_rate_sel          (slew),
    .thermal_warning_level  (warn)
  );

  dbcr_host_model u_host (
    .clock    (clock),
    .sda_wire (sda_wire),
    .scl      (scl),
    .sda_drv  (sda_drv)
  );

  always #10 clock = ~clock;

  task automatic chk(input logic [7:0] got, exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_rd(input logic [7:0] p, v, m);
    u_host.wr(7'h61, p, v, ack);
    chk({7'h0, ack}, 8'h01);
    u_host.rd(7'h61, p, rd, ack);
    chk(rd, v & m);
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #1_600_000;
    error_cnt++;
    complete_run();
  end

  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    otp_load = 1'b0;
    otp_data = 32'h0;
    tab = '{8'ha2, 8'h48, 8'h0a, 8'h64};
    repeat (5) @(negedge clock);
    nrst = 1'b1;
    @(negedge clock);
    chk(out_pg, 8'ha2);
    chk(limit, 8'h48);
    chk(out_at, 8'h0a);
    chk({1'b0, slave_addr}, 8'h61);
    chk(out_fw, 8'h64);
    for (int i = 0; i < 4; i++) begin
      u_host.rd(7'h61, 8'hd1 + 8'(i), rd, ack);
      chk({7'h0, ack}, 8'h01);
      chk(rd, tab[i]);
    end
    $display("test reset_defaults done");
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      d = {c[0], 1'b1, c[1:0], 1'b1, ~c[1:0], c[1]};
      wr_rd(8'hd1, d, 8'hb7);
      chk(out_pg, d & 8'hb7);
      wr_rd(8'hd3, {5'b00001, c}, 8'hff);
      chk(out_at, {5'b00001, c});
      d = {c[1:0], ~c[1:0], 1'b1, c};
      wr_rd(8'hd4, d, 8'hf7);
      chk(out_fw, d & 8'hf7);
    end
    tab = '{8'h14, 8'h80, 8'h48, 8'h48};
    for (int i = 0; i < 3; i++) begin
      wr_rd(8'hd2, tab[i], 8'hff);
      chk(limit, tab[i]);
    end
    $display("test field_codes done");
    u_host.wr(7'h61, 8'hd3, 8'haa, ack);
    chk({7'h0, ack}, 8'h01);
    chk({1'b0, slave_addr}, 8'h75);
    u_host.rd(7'h61, 8'hd3, rd, ack);
    chk({7'h0, ack}, 8'h00);
    u_host.rd(7'h75, 8'hd3, rd, ack);
    chk({7'h0, ack}, 8'h01);
    chk(rd, 8'haa);
    u_host.wr(7'h75, 8'hd3, 8'h0a, ack);
    chk({7'h0, ack}, 8'h01);
    chk({1'b0, slave_addr}, 8'h61);
    wr_rd(8'hd5, 8'h33, 8'h00);
    $display("test slave_address done");
    otp_data = {8'hff, 8'h0b, 8'h14, 8'hff};
    otp_load = 1'b1;
    @(negedge clock);
    otp_load = 1'b0;
    chk(out_pg, 8'hb7);
    chk(limit, 8'h14);
    chk(out_at, 8'h0b);
    chk(out_fw, 8'hf7);
    u_host.rd(7'h61, 8'hd1, rd, ack);
    chk(rd, 8'hb7);
    $display("test otp_load done");
    u_host.wr2(7'h61, 8'hd1, 8'h80, 8'h30, ack);
    chk({7'h0, ack}, 8'h01);
    chk(out_pg, 8'h80);
    chk(limit, 8'h30);
    u_host.rd2(7'h61, 8'hd1, rd, d, ack);
    chk({7'h0, ack}, 8'h01);
    chk(rd, 8'h80);
    chk(d, 8'h30);
    $display("test auto_increment done");
    nrst = 1'b0;
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    @(negedge clock);
    chk(out_pg, 8'ha2);
    chk(limit, 8'h48);
    chk(out_at, 8'h0a);
    chk(out_fw, 8'h64);
    chk({1'b0, slave_addr}, 8'h61);
    $display("test mid_reset done");
    complete_run();
  end
endmodule
